/* File: hdl/sdio_supervisor.sv */
// discrete input/output supervisor of a servopump drive
//
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module sdio_supervisor #(
    parameter int HOLD_CYC = sdio_pkg::FAST_HOLD_CYC
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sdio_pkg::sdio_apb_req_t apb_req,
    output sdio_pkg::sdio_apb_rsp_t apb_rsp,
    input wire logic control_enable_in,
    input wire logic param_set_sel0,
    input wire logic param_set_sel1,
    input wire logic alarm_clear_in,
    input wire logic pq_enable_in,
    input wire logic tuning_sel0,
    input wire logic tuning_sel1,
    input wire logic safety_channel_a,
    input wire logic safety_channel_b,
    input wire logic [3:0] fault_cond_in,
    input wire logic pump_hot_in,
    input wire logic maint_due_in,
    input wire logic sto_diag_fault_in,
    input wire logic [1:0] fb_tuning_in,
    output logic fault_out,
    output logic advice_or_cooling_out,
    output logic maintenance_alert_out,
    output logic safety_integrity_out,
    output sdio_pkg::sdio_loop_t loop_out
);

    ////////////////////////////////////////////////////////////////////////
    // state record

    typedef struct packed {
        logic [8:0] s1;
        logic [8:0] s2;
        logic alm_prev;
        logic [8:0] prev;
        sdio_pkg::sdio_state_t st;
        logic [31:0] ctrl;
        logic [3:0] gpo;
        logic [31:0] sto_period;
        logic [31:0] sto_cnt;
        logic sto_expired;
        logic [3:0] alarms;
        logic fault_q;
        logic adv_q;
        logic maint_q;
        logic integ_q;
        logic [15:0] fault_hold;
        logic [15:0] maint_hold;
        sdio_pkg::sdio_loop_t loop;
        sdio_pkg::sdio_apb_rsp_t rsp;
    } sdio_regs_t;

    sdio_regs_t r_q;
    sdio_regs_t r_d;

    // input order in the sync vectors
    localparam int I_EN = 0;
    localparam int I_PS0 = 1;
    localparam int I_PS1 = 2;
    localparam int I_ALM = 3;
    localparam int I_PQ = 4;
    localparam int I_TS0 = 5;
    localparam int I_TS1 = 6;
    localparam int I_STA = 7;
    localparam int I_STB = 8;
    localparam logic [15:0] HOLD_LAST = 16'(HOLD_CYC - 1);

    // every discrete input in one vector, bit order as listed above;
    // the whole vector walks through the same two sync stages
    logic [8:0] pins;
    assign pins = {
        safety_channel_b,
        safety_channel_a,
        tuning_sel1,
        tuning_sel0,
        pq_enable_in,
        alarm_clear_in,
        param_set_sel1,
        param_set_sel0,
        control_enable_in
    };

    // pin pair to tuning profile, an unused code keeps dynamic
    function automatic logic [1:0] sdio_tune_code(input logic [1:0] pin);
        logic [1:0] v;
        v = sdio_pkg::TUNE_DYNAMIC;
        case (pin)
            2'h1: v = sdio_pkg::TUNE_BALANCED;
            2'h2: v = sdio_pkg::TUNE_SMOOTH;
            default: v = sdio_pkg::TUNE_DYNAMIC;
        endcase
        return v;
    endfunction : sdio_tune_code

    // rate limiter: a change passes only when the hold time has elapsed
    // a level wanted for less than the hold after a change is never shown,
    // which keeps a chattering cause off the fast outputs
    function automatic logic [16:0] sdio_limit(input logic cur,
            input logic want, input logic [15:0] hold);
        logic [16:0] v;
        v = {cur, hold};
        if (hold != 16'h0000) begin
            v = {cur, 16'(hold - 16'h0001)};
        end else if (want != cur) begin
            v = {want, HOLD_LAST};
        end
        return v;
    endfunction : sdio_limit

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic sto_on;
        logic alm_rise;
        logic any_fault;
        logic test_seen;
        logic want_fault;
        logic want_adv;
        logic want_maint;
        logic want_integ;
        logic [1:0] tsrc;
        logic [16:0] lim;
        logic acc;
        logic [31:0] stat;
        sto_on = 1'b0;
        alm_rise = 1'b0;
        any_fault = 1'b0;
        test_seen = 1'b0;
        want_fault = 1'b0;
        want_adv = 1'b0;
        want_maint = 1'b0;
        want_integ = 1'b0;
        tsrc = 2'h0;
        lim = 17'h0_0000;
        acc = 1'b0;
        stat = 32'h0000_0000;
        r_d = r_q;

        // two stage input sync, second stage alone is read
        // the third copy, prev, exists only to see the step into both low
        r_d.s1 = pins;
        r_d.s2 = r_q.s1;
        r_d.prev = r_q.s2;
        r_d.alm_prev = r_q.s2[I_ALM];
        alm_rise = r_q.s2[I_ALM] & ~r_q.alm_prev;

        // safe torque off needs both channels low
        sto_on = ~r_q.s2[I_STA] & ~r_q.s2[I_STB];

        // a test is an engage of safe torque off; it restarts the period
        // a channel dropped alone is no test; only the step into both low
        test_seen = sto_on & (r_q.prev[I_STA] | r_q.prev[I_STB]);
        if (test_seen) begin
            r_d.sto_cnt = 32'h0000_0000;
            r_d.sto_expired = 1'b0;
        end else if (r_q.sto_cnt >= r_q.sto_period) begin
            r_d.sto_expired = 1'b1;
        end else begin
            r_d.sto_cnt = r_q.sto_cnt + 32'h0000_0001;
        end

        // latch fault causes; a new cause beats a clear in the same cycle
        // a cause still present at the clear stays latched
        if (alm_rise) begin
            r_d.alarms = fault_cond_in;
        end else begin
            r_d.alarms = r_q.alarms | fault_cond_in;
        end
        any_fault = (r_q.alarms != 4'h0);

        // loop settings
        r_d.loop.motor_en = r_q.s2[I_EN] & ~sto_on & ~r_q.sto_expired
            & (r_q.st == sdio_pkg::SDIO_RUN);
        r_d.loop.param_set = {r_q.s2[I_PS1], r_q.s2[I_PS0]};
        r_d.loop.pq_active = r_q.ctrl[sdio_pkg::CTRL_PQ_ASSIGN]
            ? r_q.s2[I_PQ] : 1'b1;
        tsrc = r_q.ctrl[sdio_pkg::CTRL_TUNE_SRC_LO +: 2];
        case (tsrc)
            sdio_pkg::TSRC_FIELDBUS: r_d.loop.tuning =
                sdio_tune_code(fb_tuning_in);
            sdio_pkg::TSRC_PINS: r_d.loop.tuning =
                sdio_tune_code({r_q.s2[I_TS1], r_q.s2[I_TS0]});
            default: r_d.loop.tuning =
                sdio_tune_code(r_q.ctrl[sdio_pkg::CTRL_TUNE_SW_LO +: 2]);
        endcase
        r_d.loop.fb_ref = r_q.ctrl[sdio_pkg::CTRL_FB_REF];
        r_d.loop.mon_sel = r_q.ctrl[sdio_pkg::CTRL_MON_SEL_LO +: 4];
        r_d.loop.gate_off = sto_on;

        // status functions, or software levels when reassigned
        want_fault = ~(any_fault | sto_on);
        want_adv = r_q.ctrl[sdio_pkg::CTRL_COOLING_VAR]
            ? pump_hot_in : r_q.sto_expired;
        want_maint = maint_due_in;
        want_integ = sto_diag_fault_in;
        if (r_q.ctrl[sdio_pkg::CTRL_GPO_SEL_LO]) begin
            want_fault = r_q.gpo[0];
        end
        if (r_q.ctrl[sdio_pkg::CTRL_GPO_SEL_LO + 1]) begin
            want_adv = r_q.gpo[1];
        end
        if (r_q.ctrl[sdio_pkg::CTRL_GPO_SEL_LO + 2]) begin
            want_maint = r_q.gpo[2];
        end
        if (r_q.ctrl[sdio_pkg::CTRL_GPO_SEL_LO + 3]) begin
            want_integ = r_q.gpo[3];
        end

        // supervisor state: outputs stay inactive until evaluated
        // the locked state keeps every output alive, only the motor stops
        case (r_q.st)
            sdio_pkg::SDIO_EVAL: begin
                r_d.st = sdio_pkg::SDIO_RUN;
            end
            sdio_pkg::SDIO_RUN: begin
                if (r_q.sto_expired) begin
                    r_d.st = sdio_pkg::SDIO_LOCK;
                end
                lim = sdio_limit(r_q.fault_q, want_fault, r_q.fault_hold);
                r_d.fault_q = lim[16];
                r_d.fault_hold = lim[15:0];
                lim = sdio_limit(r_q.maint_q, want_maint, r_q.maint_hold);
                r_d.maint_q = lim[16];
                r_d.maint_hold = lim[15:0];
                r_d.adv_q = want_adv;
                r_d.integ_q = want_integ;
            end
            sdio_pkg::SDIO_LOCK: begin
                if (test_seen) begin
                    r_d.st = sdio_pkg::SDIO_RUN;
                end
                lim = sdio_limit(r_q.fault_q, want_fault, r_q.fault_hold);
                r_d.fault_q = lim[16];
                r_d.fault_hold = lim[15:0];
                lim = sdio_limit(r_q.maint_q, want_maint, r_q.maint_hold);
                r_d.maint_q = lim[16];
                r_d.maint_hold = lim[15:0];
                r_d.adv_q = want_adv;
                r_d.integ_q = want_integ;
            end
            default: r_d.st = sdio_pkg::SDIO_EVAL;
        endcase

        // status word, one field to a line
        stat[15] = r_q.fault_q;
        stat[14] = r_q.adv_q;
        stat[13] = r_q.maint_q;
        stat[12] = r_q.integ_q;
        stat[11] = r_q.loop.motor_en;
        stat[10] = sto_on;
        stat[9] = r_q.sto_expired;
        stat[8] = r_q.loop.pq_active;
        stat[7:6] = r_q.loop.param_set;
        stat[5:4] = r_q.loop.tuning;
        stat[3:1] = r_q.st;

        // apb slave: answer in the access cycle, zero wait states
        // pready is registered from the setup cycle, so it stands in the
        // access cycle; the write lands at the edge that ends that cycle
        r_d.rsp.pready = 1'b0;
        r_d.rsp.pslverr = 1'b0;
        r_d.rsp.prdata = 32'h0000_0000;
        acc = apb_req.psel & apb_req.penable & r_q.rsp.pready;
        if (apb_req.psel & ~apb_req.penable) begin
            r_d.rsp.pready = 1'b1;
            case (apb_req.paddr)
                sdio_pkg::OFF_CTRL: r_d.rsp.prdata = r_q.ctrl;
                sdio_pkg::OFF_GPO: r_d.rsp.prdata = {28'h0, r_q.gpo};
                sdio_pkg::OFF_STATUS: r_d.rsp.prdata = stat;
                sdio_pkg::OFF_CAUSE: r_d.rsp.prdata = {28'h0, r_q.alarms};
                sdio_pkg::OFF_STO_PERIOD: r_d.rsp.prdata = r_q.sto_period;
                default: r_d.rsp.pslverr = 1'b1;
            endcase
        end
        if (acc & apb_req.pwrite) begin
            case (apb_req.paddr)
                sdio_pkg::OFF_CTRL: r_d.ctrl = apb_req.pwdata;
                sdio_pkg::OFF_GPO: r_d.gpo = apb_req.pwdata[3:0];
                sdio_pkg::OFF_STO_PERIOD: r_d.sto_period = apb_req.pwdata;
                default: r_d.gpo = r_q.gpo;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // one flop record; reset puts the status outputs at their idle levels
    // so nothing is announced before the first evaluation
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.st <= sdio_pkg::SDIO_EVAL;
            r_q.ctrl <= sdio_pkg::CTRL_RST;
            r_q.sto_period <= sdio_pkg::STO_PERIOD_RST;
            r_q.s1 <= 9'h180; // safety channels idle high
            r_q.s2 <= 9'h180;
            r_q.prev <= 9'h180;
            r_q.fault_q <= 1'b1; // fault output idles at no fault
            r_q.loop.pq_active <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // outputs straight from flops
    assign apb_rsp = r_q.rsp;
    assign fault_out = r_q.fault_q;
    assign advice_or_cooling_out = r_q.adv_q;
    assign maintenance_alert_out = r_q.maint_q;
    assign safety_integrity_out = r_q.integ_q;
    assign loop_out = r_q.loop;

endmodule : sdio_supervisor

/* File: pkg/sdio_pkg.sv */
// package for the servo drive discrete io supervisor
package sdio_pkg;
    // apb register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_GPO = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_CAUSE = 8'h0c;
    localparam logic [7:0] OFF_STO_PERIOD = 8'h10;
    // ctrl field positions
    localparam int CTRL_GPO_SEL_LO = 0;
    localparam int CTRL_PQ_ASSIGN = 4;
    localparam int CTRL_COOLING_VAR = 5;
    localparam int CTRL_FB_REF = 6;
    localparam int CTRL_MON_SEL_LO = 8;
    localparam int CTRL_TUNE_SRC_LO = 12;
    localparam int CTRL_TUNE_SW_LO = 14;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // clock and output toggle limit
    localparam int CLK_HZ = 250_000_000;
    localparam int FAST_MAX_HZ = 5_000;
    localparam int FAST_HOLD_CYC = CLK_HZ / FAST_MAX_HZ;
    // default period between required safe torque off tests, in cycles
    localparam logic [31:0] STO_PERIOD_RST = 32'h0100_0000;
    // tuning profile codes
    localparam logic [1:0] TUNE_DYNAMIC = 2'h0;
    localparam logic [1:0] TUNE_BALANCED = 2'h1;
    localparam logic [1:0] TUNE_SMOOTH = 2'h2;
    // tuning source codes
    localparam logic [1:0] TSRC_SW = 2'h0;
    localparam logic [1:0] TSRC_FIELDBUS = 2'h1;
    localparam logic [1:0] TSRC_PINS = 2'h2;
    // supervisor states
    typedef enum logic [2:0] {
        SDIO_EVAL = 3'b001,
        SDIO_RUN = 3'b010,
        SDIO_LOCK = 3'b100
    } sdio_state_t;
    // apb request and answer
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } sdio_apb_req_t;
    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } sdio_apb_rsp_t;
    // settings handed to the control loops
    typedef struct packed {
        logic motor_en;
        logic [1:0] param_set;
        logic pq_active;
        logic [1:0] tuning;
        logic fb_ref;
        logic [3:0] mon_sel;
        logic gate_off;
    } sdio_loop_t;
endpackage : sdio_pkg

/* File: test/sdio_mcu_model.sv */
// machine controller model driving the discrete input levels
`timescale 1ns/1ps
module sdio_mcu_model (
    input wire logic mclk,
    input wire logic [8:0] want,
    output logic [8:0] pins
);
    ////////////////////////////////////////////////////////////////////////
    // levels move just after an edge; safety channels idle high when unused
    always_ff @(posedge mclk) begin
        pins <= want;
    end
endmodule : sdio_mcu_model

/* File: test/sdio_supervisor_properties.sv */
// concurrent checks on the ports of the io supervisor
`timescale 1ns/1ps
module sdio_checker #(
    parameter int HOLD_CYC = 8
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire sdio_pkg::sdio_apb_req_t apb_req,
    input wire logic control_enable_in,
    input wire logic param_set_sel0,
    input wire logic param_set_sel1,
    input wire logic pq_enable_in,
    input wire logic safety_channel_a,
    input wire logic safety_channel_b,
    input wire logic maint_due_in,
    input wire logic sto_diag_fault_in,
    input wire logic fault_out,
    input wire logic maintenance_alert_out,
    input wire logic safety_integrity_out,
    input wire sdio_pkg::sdio_loop_t loop_out
);
    logic [31:0] ctrl_q;
    logic [31:0] age_q;
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    // mirror of the control word and age of the fault output level
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 32'h0;
            age_q <= 32'hffff;
        end else begin
            if (apb_req.psel && apb_req.penable && apb_req.pwrite
                && apb_req.paddr == sdio_pkg::OFF_CTRL)
                ctrl_q <= apb_req.pwdata;
            if ($changed(fault_out))
                age_q <= 32'h0;
            else if (age_q != 32'hffff)
                age_q <= age_q + 32'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    gate_on_a: assert property (
        (!safety_channel_a && !safety_channel_b)[*5] |-> loop_out.gate_off)
        else $error("gate drive not removed");
    gate_keep_a: assert property (safety_channel_a[*5]
        |-> !loop_out.gate_off) else $error("gate drive removed");
    motor_off_a: assert property ((!control_enable_in)[*5]
        |-> !loop_out.motor_en) else $error("motor runs while disabled");
    set_pick_a: assert property (
        $stable({param_set_sel1, param_set_sel0})[*5]
        |-> loop_out.param_set == {param_set_sel1, param_set_sel0})
        else $error("wrong parameter set");
    pq_default_a: assert property ((!ctrl_q[4])[*3]
        |-> loop_out.pq_active) else $error("pq control not active");
    pq_pin_a: assert property ((ctrl_q[4] && $stable(pq_enable_in))[*5]
        |-> loop_out.pq_active == pq_enable_in)
        else $error("pq not from input");
    fault_rate_a: assert property ($changed(fault_out)
        |-> age_q >= HOLD_CYC - 1) else $error("fault output toggles too fast");
    sto_fault_a: assert property ((!safety_channel_a && !safety_channel_b
        && !ctrl_q[0])[*8] |-> ##[0:12] !fault_out)
        else $error("fault output high under torque off");
    maint_out_a: assert property ((maint_due_in && !ctrl_q[2])[*8]
        |-> ##[0:8] maintenance_alert_out) else $error("no maintenance alert");
    integ_out_a: assert property ((sto_diag_fault_in && !ctrl_q[3])[*4]
        |-> safety_integrity_out) else $error("no integrity alert");
endmodule : sdio_checker

/* File: test/sdio_supervisor_tb_top.sv */
// self-checking bench for the discrete io supervisor
`timescale 1ns/1ps
module sdio_supervisor_tb_top;
    logic mclk, rst_n, pump_hot_in, maint_due_in, sto_diag_fault_in, err;
    logic fault_out, advice_or_cooling_out, maintenance_alert_out;
    logic safety_integrity_out;
    logic [1:0] fb_tuning_in;
    logic [3:0] fault_cond_in, outs;
    logic [8:0] want, pins;
    logic [31:0] rd;
    sdio_pkg::sdio_apb_req_t apb_req;
    sdio_pkg::sdio_apb_rsp_t apb_rsp;
    sdio_pkg::sdio_loop_t loop_out;
    int bad_count, n_tests;
    ////////////////////////////////////////////////////////////////////////
    // partner, design and output bundle (bit 0 is the fault output)
    sdio_mcu_model mcu (.mclk, .want, .pins);
    sdio_supervisor #(.HOLD_CYC(8)) dut (.mclk, .rst_n, .apb_req, .apb_rsp,
        .control_enable_in(pins[0]), .param_set_sel0(pins[1]),
        .param_set_sel1(pins[2]), .alarm_clear_in(pins[3]),
        .pq_enable_in(pins[4]), .tuning_sel0(pins[5]), .tuning_sel1(pins[6]),
        .safety_channel_a(pins[7]), .safety_channel_b(pins[8]),
        .fault_cond_in, .pump_hot_in, .maint_due_in, .sto_diag_fault_in,
        .fb_tuning_in, .fault_out, .advice_or_cooling_out,
        .maintenance_alert_out, .safety_integrity_out, .loop_out);
    assign outs = {safety_integrity_out, maintenance_alert_out,
        advice_or_cooling_out, fault_out};
    ////////////////////////////////////////////////////////////////////////
    // clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
            input logic [31:0] d);
        @(posedge mclk);
        apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a,
            pwdata: d};
        @(posedge mclk);
        apb_req.penable <= 1'b1;
        // wait for pready; only the watchdog ends a hung transfer
        do begin
            @(posedge mclk);
        end while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        err = apb_rsp.pslverr;
        apb_req <= '0;
    endtask : apb
    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        cyc(5000);
        bad_count++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        apb_req = '0;
        want = 9'h180;
        fault_cond_in = 4'h0;
        {pump_hot_in, maint_due_in, sto_diag_fault_in} = 3'h0;
        fb_tuning_in = 2'h0;
        rst_n = 1'b0;
        bad_count = 0;
        n_tests = 0;
        cyc(8);
        chk("outs_in_reset", 32'h1, outs);
        rst_n <= 1'b1;
        cyc(6);
        chk("tuning_default", 32'h0, loop_out.tuning);
        apb(1'b0, sdio_pkg::OFF_STO_PERIOD, 32'h0);
        chk("period_reset", 32'h0100_0000, rd);
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped_err", 32'h1, err);
        $display("reset test done");
        for (int i = 0; i < 4; i++) begin
            want[2:0] <= {i[1:0], 1'b1};
            cyc(6);
            chk("param_set", i, loop_out.param_set);
            chk("motor_run", 32'h1, loop_out.motor_en);
        end
        want[0] <= 1'b0;
        cyc(6);
        chk("motor_stop", 32'h0, loop_out.motor_en);
        chk("fault_indep", 32'h1, fault_out);
        want[0] <= 1'b1;
        $display("enable test done");
        fault_cond_in <= 4'h1;
        cyc(16);
        chk("fault_low", 32'h0, fault_out);
        fault_cond_in <= 4'h0;
        cyc(16);
        chk("fault_latched", 32'h0, fault_out);
        want[3] <= 1'b1;
        cyc(3);
        want[3] <= 1'b0;
        cyc(16);
        chk("fault_cleared", 32'h1, fault_out);
        apb(1'b0, sdio_pkg::OFF_CAUSE, 32'h0);
        chk("cause_clear", 32'h0, rd);
        $display("alarm test done");
        want[8:7] <= 2'b01;
        cyc(8);
        chk("one_channel", 32'h0, loop_out.gate_off);
        want[8:7] <= 2'b00;
        cyc(16);
        chk("gate_off", 32'h1, loop_out.gate_off);
        chk("sto_fault", 32'h0, fault_out);
        want[8:7] <= 2'b11;
        apb(1'b1, sdio_pkg::OFF_STO_PERIOD, 32'h14);
        apb(1'b0, sdio_pkg::OFF_STO_PERIOD, 32'h0);
        chk("period_write", 32'h14, rd);
        cyc(40);
        chk("sto_lock", 32'h0, loop_out.motor_en);
        chk("test_advice", 32'h1, advice_or_cooling_out);
        apb(1'b1, sdio_pkg::OFF_STO_PERIOD, 32'h0100_0000);
        want[8:7] <= 2'b00;
        cyc(8);
        want[8:7] <= 2'b11;
        cyc(16);
        chk("sto_unlock", 32'h1, loop_out.motor_en);
        chk("advice_off", 32'h0, advice_or_cooling_out);
        $display("sto test done");
        apb(1'b1, sdio_pkg::OFF_CTRL, 32'h20);
        pump_hot_in <= 1'b1;
        cyc(6);
        chk("cooling_on", 32'h1, advice_or_cooling_out);
        pump_hot_in <= 1'b0;
        cyc(6);
        chk("cooling_off", 32'h0, advice_or_cooling_out);
        chk("pq_default", 32'h1, loop_out.pq_active);
        apb(1'b1, sdio_pkg::OFF_CTRL, 32'h10);
        cyc(6);
        chk("pq_flow_only", 32'h0, loop_out.pq_active);
        want[4] <= 1'b1;
        cyc(6);
        chk("pq_both", 32'h1, loop_out.pq_active);
        $display("mode test done");
        fb_tuning_in <= 2'h1;
        want[6:5] <= 2'b10;
        apb(1'b1, sdio_pkg::OFF_CTRL, 32'h8000);
        cyc(6);
        chk("tune_sw", 32'h2, loop_out.tuning);
        apb(1'b1, sdio_pkg::OFF_CTRL, 32'h1000);
        cyc(6);
        chk("tune_fieldbus", 32'h1, loop_out.tuning);
        apb(1'b1, sdio_pkg::OFF_CTRL, 32'h2540);
        cyc(6);
        chk("tune_pins", 32'h2, loop_out.tuning);
        chk("fb_ref", 32'h1, loop_out.fb_ref);
        chk("mon_sel", 32'h5, loop_out.mon_sel);
        $display("tuning test done");
        maint_due_in <= 1'b1;
        sto_diag_fault_in <= 1'b1;
        cyc(20);
        chk("maint_alert", 32'h1, maintenance_alert_out);
        chk("integ_alert", 32'h1, safety_integrity_out);
        apb(1'b1, sdio_pkg::OFF_CTRL, 32'hf);
        apb(1'b1, sdio_pkg::OFF_GPO, 32'h5);
        cyc(16);
        chk("gpo_5", 32'h5, outs);
        apb(1'b1, sdio_pkg::OFF_GPO, 32'ha);
        cyc(16);
        chk("gpo_a", 32'ha, outs);
        $display("output test done");
        summarize();
    end
endmodule : sdio_supervisor_tb_top
bind sdio_supervisor sdio_checker #(.HOLD_CYC(HOLD_CYC)) props (.mclk, .rst_n,
    .apb_req, .control_enable_in, .param_set_sel0, .param_set_sel1,
    .pq_enable_in, .safety_channel_a, .safety_channel_b, .maint_due_in,
    .sto_diag_fault_in, .fault_out, .maintenance_alert_out,
    .safety_integrity_out, .loop_out);
